// *** src/bus_ctrl_port.sv ***
// bus control port with wishbone registers, plus the input-only port
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
`include "port_map.svh"

module bus_ctrl_port
    import port_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [6:0]  bus_pin_i,
    output logic      [6:0]  bus_pin_o,
    output logic      [6:0]  bus_pin_oe_o,
    input  wire logic [7:0]  input_pin_i,
    input  wire logic        hw_standby_i,
    input  wire logic        low_write_strobe_n_i,
    input  wire logic        high_write_strobe_n_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic        address_strobe_n_i,
    input  wire logic        bus_release_ack_n_i,
    output logic             bus_request_in_n_o,
    output logic             wait_n_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] word_index(input logic [17:0] adr);
        word_index = adr[17:2];
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [6:0] bus_pin_meta;
    logic [6:0] bus_pin_sync;
    logic [7:0] input_pin_meta;
    logic [7:0] input_pin_sync;
    logic       standby_meta;
    logic       standby_sync;
    logic [6:0] next_bus_pin_meta;
    logic [6:0] next_bus_pin_sync;
    logic [7:0] next_input_pin_meta;
    logic [7:0] next_input_pin_sync;
    logic       next_standby_meta;
    logic       next_standby_sync;

    always_comb begin
        next_bus_pin_meta   = bus_pin_i;
        next_bus_pin_sync   = bus_pin_meta;
        next_input_pin_meta = input_pin_i;
        next_input_pin_sync = input_pin_meta;
        next_standby_meta   = hw_standby_i;
        next_standby_sync   = standby_meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_pin_meta   <= 7'h7f;
            bus_pin_sync   <= 7'h7f;
            input_pin_meta <= 8'h00;
            input_pin_sync <= 8'h00;
            standby_meta   <= 1'b0;
            standby_sync   <= 1'b0;
        end else begin
            bus_pin_meta   <= next_bus_pin_meta;
            bus_pin_sync   <= next_bus_pin_sync;
            input_pin_meta <= next_input_pin_meta;
            input_pin_sync <= next_input_pin_sync;
            standby_meta   <= next_standby_meta;
            standby_sync   <= next_standby_sync;
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave handshake
    // ------------------------------------------------------------------
    logic        bus_hit;
    logic        write_now;
    logic [15:0] req_index;
    logic        next_ack;
    logic [31:0] next_dat;

    // ack is high one cycle after the request, so the write lands on the
    // same edge at which the master samples ack
    always_comb begin
        bus_hit   = wb_cyc_i && wb_stb_i;
        req_index = word_index(wb_adr_i);
        next_ack  = bus_hit && !wb_ack_o;
        write_now = bus_hit && wb_ack_o && wb_we_i && wb_sel_i[0];
    end

    // ------------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------------
    logic [7:0] direction;
    logic [7:0] output_data;
    logic [7:0] release_ctrl;
    logic [7:0] wait_ctrl;
    logic [7:0] wait_enable;
    logic [7:0] port_mode;
    logic [7:0] next_direction;
    logic [7:0] next_output_data;
    logic [7:0] next_release_ctrl;
    logic [7:0] next_wait_ctrl;
    logic [7:0] next_wait_enable;
    logic [7:0] next_port_mode;
    logic       reg_clear;

    always_comb begin
        reg_clear         = standby_sync;
        // no software standby input: holding is the default, only hardware standby clears
        next_direction    = direction;
        next_output_data  = output_data;
        next_release_ctrl = release_ctrl;
        next_wait_ctrl    = wait_ctrl;
        next_wait_enable  = wait_enable;
        next_port_mode    = port_mode;
        if (write_now) begin
            case (req_index)
                `BUS_PORT_DIRECTION_IDX: begin
                    next_direction = {1'b1, wb_dat_i[6:0]};
                end
                `BUS_PORT_OUTPUT_DATA_IDX: begin
                    next_output_data = {1'b1, wb_dat_i[6:0]};
                end
                `BUS_RELEASE_CONTROL_REG_IDX: begin
                    next_release_ctrl = {7'h00, wb_dat_i[`BUS_RELEASE_ENABLE_BIT]};
                end
                `WAIT_CONTROL_REG_IDX: begin
                    next_wait_ctrl = {6'h00, wb_dat_i[`WAIT_MODE_SELECT_HI_BIT], 1'b0};
                end
                `WAIT_ENABLE_BITS_IDX: begin
                    next_wait_enable = wb_dat_i[7:0];
                end
                `PORT_MODE_IDX: begin
                    next_port_mode = {7'h00, wb_dat_i[`SINGLE_CHIP_BIT]};
                end
                // input port and unmapped words take writes without effect
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || reg_clear) begin
            direction    <= `BUS_PORT_DIRECTION_RST;
            output_data  <= `BUS_PORT_OUTPUT_DATA_RST;
            release_ctrl <= `BUS_RELEASE_CONTROL_RST;
            wait_ctrl    <= `WAIT_CONTROL_RST;
            wait_enable  <= `WAIT_ENABLE_BITS_RST;
            port_mode    <= `PORT_MODE_RST;
        end else begin
            direction    <= next_direction;
            output_data  <= next_output_data;
            release_ctrl <= next_release_ctrl;
            wait_ctrl    <= next_wait_ctrl;
            wait_enable  <= next_wait_enable;
            port_mode    <= next_port_mode;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [7:0] data_readback;

    always_comb begin
        // pin levels seen through the synchroniser, two cycles behind
        data_readback = {1'b1, (direction[6:0] & output_data[6:0])
                              | (~direction[6:0] & bus_pin_sync)};
        next_dat = `UNMAPPED_READ;
        if (next_ack && !wb_we_i) begin
            case (req_index)
                `BUS_PORT_DIRECTION_IDX: begin
                    next_dat = {24'h0000_00, `WRITE_ONLY_READ};
                end
                `BUS_PORT_OUTPUT_DATA_IDX: begin
                    next_dat = {24'h0000_00, data_readback};
                end
                `INPUT_PORT_LEVELS_IDX: begin
                    next_dat = {24'h0000_00, input_pin_sync};
                end
                `BUS_RELEASE_CONTROL_REG_IDX: begin
                    next_dat = {24'h0000_00, release_ctrl};
                end
                `WAIT_CONTROL_REG_IDX: begin
                    next_dat = {24'h0000_00, wait_ctrl};
                end
                `WAIT_ENABLE_BITS_IDX: begin
                    next_dat = {24'h0000_00, wait_enable};
                end
                `PORT_MODE_IDX: begin
                    next_dat = {24'h0000_00, port_mode};
                end
                default: begin
                    next_dat = `UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `UNMAPPED_READ;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ------------------------------------------------------------------
    // pin function multiplexer
    // ------------------------------------------------------------------
    pin_mux_if mux_bus ();

    always_comb begin
        mux_bus.ctrl.single_chip         = port_mode[`SINGLE_CHIP_BIT];
        mux_bus.ctrl.bus_release_enable  = release_ctrl[`BUS_RELEASE_ENABLE_BIT];
        mux_bus.ctrl.wait_mode_select_hi = wait_ctrl[`WAIT_MODE_SELECT_HI_BIT];
        mux_bus.ctrl.wait_enable_bits    = wait_enable;
        mux_bus.direction     = direction[6:0];
        mux_bus.output_data   = output_data[6:0];
        mux_bus.strobes_n     = {low_write_strobe_n_i, high_write_strobe_n_i,
                                 read_strobe_n_i, address_strobe_n_i};
        mux_bus.release_ack_n = bus_release_ack_n_i;
    end

    port_pin_mux u_mux (
        .mx (mux_bus.mux)
    );

    // ------------------------------------------------------------------
    // registered pin drivers and bus inputs
    // ------------------------------------------------------------------
    logic [6:0] next_pin_out;
    logic [6:0] next_pin_oe;
    logic       next_request_n;
    logic       next_wait_n;

    // pins float in hardware standby; inactive-high bus inputs otherwise
    always_comb begin
        next_pin_out   = mux_bus.pin_out;
        next_pin_oe    = standby_sync ? 7'h00 : mux_bus.pin_oe;
        next_request_n = (mux_bus.pin_func[1] == FUNC_BUS_IN)
                         ? bus_pin_sync[1] : 1'b1;
        next_wait_n    = (mux_bus.pin_func[0] == FUNC_BUS_IN)
                         ? bus_pin_sync[0] : 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_pin_o          <= 7'h7f;
            bus_pin_oe_o       <= 7'h00;
            bus_request_in_n_o <= 1'b1;
            wait_n_o           <= 1'b1;
        end else begin
            bus_pin_o          <= next_pin_out;
            bus_pin_oe_o       <= next_pin_oe;
            bus_request_in_n_o <= next_request_n;
            wait_n_o           <= next_wait_n;
        end
    end

endmodule

// *** src/port_map.svh ***
// register indices, field positions, reset values and bus timing for the bus control port
`ifndef PORT_MAP_SVH
`define PORT_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define BUS_PORT_DIRECTION_IDX        16'hffc9
`define BUS_PORT_OUTPUT_DATA_IDX      16'hffcb
`define INPUT_PORT_LEVELS_IDX         16'hffce
`define BUS_RELEASE_CONTROL_REG_IDX   16'hffd0
`define WAIT_CONTROL_REG_IDX          16'hffd1
`define WAIT_ENABLE_BITS_IDX          16'hffd2
`define PORT_MODE_IDX                 16'hffd3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RESERVED_BIT                  7
`define BUS_RELEASE_ENABLE_BIT        0
`define WAIT_MODE_SELECT_HI_BIT       1
`define SINGLE_CHIP_BIT               0

// ----------------------------------------------------------------------
// reset values and fixed read values
// ----------------------------------------------------------------------
`define BUS_PORT_DIRECTION_RST        8'h80
`define BUS_PORT_OUTPUT_DATA_RST      8'h80
`define BUS_RELEASE_CONTROL_RST       8'h00
`define WAIT_CONTROL_RST              8'h00
`define WAIT_ENABLE_BITS_RST          8'hff
`define PORT_MODE_RST                 8'h01
`define WAIT_ENABLE_ALL_ONES          8'hff
`define WRITE_ONLY_READ               8'hff
`define UNMAPPED_READ                 32'h0000_0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ACK_LATENCY_CYCLES            1

`endif

// *** src/port_pkg.sv ***
// types shared by the bus control port and its pin multiplexer
package port_pkg;

    // ------------------------------------------------------------------
    // pin function of one bidirectional port pin
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FUNC_GPIO,
        FUNC_STROBE_OUT,
        FUNC_RELEASE_OUT,
        FUNC_BUS_IN
    } pin_func_t;

    // ------------------------------------------------------------------
    // settings that steer the pin multiplexer
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       single_chip;
        logic       bus_release_enable;
        logic       wait_mode_select_hi;
        logic [7:0] wait_enable_bits;
    } mux_ctrl_t;

endpackage

// *** src/pin_mux_if.sv ***
// signals between the port registers and the pin function multiplexer
`timescale 1ns/100ps
interface pin_mux_if;
    import port_pkg::*;

    mux_ctrl_t       ctrl;
    logic [6:0]      direction;
    logic [6:0]      output_data;
    logic [3:0]      strobes_n;
    logic            release_ack_n;
    logic [6:0]      pin_out;
    logic [6:0]      pin_oe;
    pin_func_t [6:0] pin_func;

    modport regs (
        output ctrl,
        output direction,
        output output_data,
        output strobes_n,
        output release_ack_n,
        input  pin_out,
        input  pin_oe,
        input  pin_func
    );

    modport mux (
        input  ctrl,
        input  direction,
        input  output_data,
        input  strobes_n,
        input  release_ack_n,
        output pin_out,
        output pin_oe,
        output pin_func
    );
endinterface

// *** src/port_pin_mux.sv ***
// pin function selection for the seven bidirectional port pins
`timescale 1ns/100ps
`include "port_map.svh"
module port_pin_mux
    import port_pkg::*;
(
    pin_mux_if.mux mx
);

    logic wait_as_gpio;

    always_comb begin
        wait_as_gpio = (mx.ctrl.wait_enable_bits == `WAIT_ENABLE_ALL_ONES)
                       && !mx.ctrl.wait_mode_select_hi;
        // general i/o by default: direction 1 drives, 0 listens
        mx.pin_out  = mx.output_data;
        mx.pin_oe   = mx.direction;
        for (int k = 0; k < 7; k++) begin
            mx.pin_func[k] = FUNC_GPIO;
        end
        if (!mx.ctrl.single_chip) begin
            // strobes own the upper pins whatever the direction bits say
            mx.pin_out[6:3]  = mx.strobes_n;
            mx.pin_oe[6:3]   = 4'hf;
            for (int k = 3; k < 7; k++) begin
                mx.pin_func[k] = FUNC_STROBE_OUT;
            end
            if (mx.ctrl.bus_release_enable) begin
                mx.pin_out[2]  = mx.release_ack_n;
                mx.pin_oe[2]   = 1'b1;
                mx.pin_func[2] = FUNC_RELEASE_OUT;
                mx.pin_out[1]  = 1'b1;
                mx.pin_oe[1]   = 1'b0;
                mx.pin_func[1] = FUNC_BUS_IN;
            end
            if (!wait_as_gpio) begin
                // never drive against an external wait source
                mx.pin_out[0]  = 1'b1;
                mx.pin_oe[0]   = 1'b0;
                mx.pin_func[0] = FUNC_BUS_IN;
            end
        end
    end

endmodule

// *** dv/bus_ctrl_port_assertions.sv ***
// concurrent checks on the bus control port register bus and pins
`timescale 1ns/100ps
`include "port_map.svh"
module bus_ctrl_port_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [6:0]  bus_pin_oe_o,
    input wire logic [7:0]  input_pin_i,
    input wire logic        hw_standby_i,
    input wire logic        bus_request_in_n_o,
    input wire logic        wait_n_o
);
    logic [2:0] run_cnt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // --------
    // settle counter
    // --------
    // synchronisers still hold reset values for a few edges after release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_cnt <= 3'h0;
        end else if (run_cnt != 3'h7) begin
            run_cnt <= run_cnt + 3'h1;
        end
    end

    // --------
    // checks
    // --------
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_rsv_bit_one: assert property (wb_ack_o && !$past(wb_we_i) &&
        $past(wb_adr_i[17:2]) == `BUS_PORT_OUTPUT_DATA_IDX |-> wb_dat_o[7])
        else $error("data register bit 7 read as zero");
    a_input_levels: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
        wb_adr_i[17:2] == `INPUT_PORT_LEVELS_IDX && run_cnt == 3'h7 && $stable(input_pin_i)
        && $past(input_pin_i, 2) == input_pin_i && $past(input_pin_i, 3) == input_pin_i
        |=> wb_dat_o == {24'h00_0000, $past(input_pin_i)})
        else $error("input port read differs from pin levels");
    a_standby_no_drive: assert property (hw_standby_i [*6] |-> bus_pin_oe_o == 7'h00)
        else $error("pins driven in hardware standby");
    a_request_no_drive: assert property (!bus_request_in_n_o |-> !bus_pin_oe_o[1])
        else $error("request pin driven while taken as input");
    a_wait_no_drive: assert property (!wait_n_o |-> !bus_pin_oe_o[0])
        else $error("wait pin driven while taken as input");
endmodule

bind bus_ctrl_port bus_ctrl_port_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_pin_oe_o(bus_pin_oe_o), .input_pin_i(input_pin_i), .hw_standby_i(hw_standby_i),
    .bus_request_in_n_o(bus_request_in_n_o), .wait_n_o(wait_n_o)
);

// *** dv/pin_board_model.sv ***
// board side of the seven bidirectional port pins
`timescale 1ns/100ps
module pin_board_model (
    input  wire logic       clk_i,
    input  wire logic [6:0] pin_out_i,
    input  wire logic [6:0] pin_oe_i,
    input  wire logic [6:0] ext_level_i,
    input  wire logic [6:0] ext_drive_i,
    output logic      [6:0] pin_level_o
);
    logic [6:0] float_q = 7'h55;

    // no pull resistor: an undriven pin wanders every cycle
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end

    // clash of both drivers shows as unknown
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            if (pin_oe_i[k] && ext_drive_i[k]) begin
                pin_level_o[k] = 1'hx;
            end else if (pin_oe_i[k]) begin
                pin_level_o[k] = pin_out_i[k];
            end else if (ext_drive_i[k]) begin
                pin_level_o[k] = ext_level_i[k];
            end else begin
                pin_level_o[k] = float_q[k];
            end
        end
    end
endmodule

// *** dv/bus_ctrl_port_tb.sv ***
// self-checking bench for the bus control port and input-only port
`timescale 1ns/100ps
`include "port_map.svh"
module bus_ctrl_port_tb;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [17:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [6:0]  bus_pin_i;
    logic [6:0]  bus_pin_o;
    logic [6:0]  bus_pin_oe_o;
    logic [7:0]  input_pin_i;
    logic        hw_standby_i;
    logic [3:0]  strb_n;
    logic        rel_ack_n;
    logic        bus_request_in_n_o;
    logic        wait_n_o;
    logic [6:0]  ext_level;
    logic [6:0]  ext_drive;
    logic [6:0]  dir;
    logic [6:0]  dat;
    logic [6:0]  lvl;
    logic [31:0] exp_q[$];
    int          seed = 32'h907c_0371;
    int          fails = 0;
    int          check_count = 0;

    bus_ctrl_port u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_pin_i(bus_pin_i),
        .bus_pin_o(bus_pin_o), .bus_pin_oe_o(bus_pin_oe_o), .input_pin_i(input_pin_i),
        .hw_standby_i(hw_standby_i), .low_write_strobe_n_i(strb_n[3]),
        .high_write_strobe_n_i(strb_n[2]), .read_strobe_n_i(strb_n[1]),
        .address_strobe_n_i(strb_n[0]), .bus_release_ack_n_i(rel_ack_n),
        .bus_request_in_n_o(bus_request_in_n_o), .wait_n_o(wait_n_o)
    );

    pin_board_model u_board (
        .clk_i(clk_i), .pin_out_i(bus_pin_o), .pin_oe_i(bus_pin_oe_o),
        .ext_level_i(ext_level), .ext_drive_i(ext_drive), .pin_level_o(bus_pin_i)
    );

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end

    // --------
    // tasks
    // --------
    task automatic check_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [15:0] idx, input logic [7:0] d,
                           input logic [3:0] sel);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (wb_ack_o !== 1'h1) begin
            fails++;
            stop_test();
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        wb_xfer(1'h1, idx, d, 4'h1);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h00_0000, e});
        wb_xfer(1'h0, idx, 8'h00, 4'h1);
    endtask

    task automatic input_check();
        logic [7:0] v;
        repeat (3) begin
            v = 8'($random(seed));
            input_pin_i <= v;
            repeat (3) @(posedge clk_i);
            rd(`INPUT_PORT_LEVELS_IDX, v);
            wr(`INPUT_PORT_LEVELS_IDX, ~v);
            rd(`INPUT_PORT_LEVELS_IDX, v);
        end
    endtask

    // --------
    // read monitor
    // --------
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("wrong value read data expected none seen %h", wb_dat_o);
            end else begin
                check_val("read data", exp_q.pop_front(), wb_dat_o);
            end
        end
    end

    // --------
    // main sequence
    // --------
    initial begin
        rst_i = 1'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 54'h0;
        {input_pin_i, hw_standby_i, rel_ack_n, strb_n} = 14'h1f;
        ext_drive = 7'h7f;
        ext_level = 7'h2a;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        // pin synchroniser needs two edges to leave its reset value
        repeat (3) @(posedge clk_i);
        rd(`BUS_PORT_OUTPUT_DATA_IDX, 8'haa);
        check_val("pin oe", 32'h0, 32'(bus_pin_oe_o));
        rd(16'hffca, 8'h00);
        repeat (6) begin
            {dir, dat, lvl} = 21'($random(seed));
            wr(`BUS_PORT_DIRECTION_IDX, {1'h0, dir});
            ext_drive <= ~dir;
            ext_level <= lvl;
            wr(`BUS_PORT_OUTPUT_DATA_IDX, {1'h0, dat});
            repeat (4) @(posedge clk_i);
            check_val("pin oe", 32'(dir), 32'(bus_pin_oe_o));
            check_val("pin out", 32'(dir & dat), 32'(dir & bus_pin_o));
            rd(`BUS_PORT_OUTPUT_DATA_IDX, {1'h1, (dir & dat) | (~dir & lvl)});
        end
        ext_drive <= 7'h00;
        wr(`BUS_PORT_DIRECTION_IDX, 8'h7f);
        wr(`BUS_PORT_OUTPUT_DATA_IDX, 8'h55);
        wb_xfer(1'h1, `BUS_PORT_OUTPUT_DATA_IDX, 8'h2a, 4'h0);
        repeat (20) @(posedge clk_i);
        rd(`BUS_PORT_OUTPUT_DATA_IDX, 8'hd5);
        input_check();
        // expanded mode, pin 0 direction kept at zero for the wait role
        lvl = 7'($random(seed));
        ext_level <= lvl;
        strb_n <= 4'($random(seed));
        rel_ack_n <= 1'($random(seed));
        wr(`BUS_PORT_DIRECTION_IDX, 8'h06);
        ext_drive <= 7'h01;
        wr(`PORT_MODE_IDX, 8'h00);
        repeat (4) @(posedge clk_i);
        check_val("pin oe", 32'h7e, 32'(bus_pin_oe_o));
        check_val("strobes", 32'(strb_n), 32'(bus_pin_o[6:3]));
        check_val("wait", 32'h1, 32'(wait_n_o));
        wr(`BUS_RELEASE_CONTROL_REG_IDX, 8'h01);
        ext_drive <= 7'h03;
        repeat (4) @(posedge clk_i);
        check_val("pin oe", 32'h7c, 32'(bus_pin_oe_o));
        check_val("release ack", 32'(rel_ack_n), 32'(bus_pin_o[2]));
        check_val("request", 32'(lvl[1]), 32'(bus_request_in_n_o));
        wr(`WAIT_ENABLE_BITS_IDX, 8'hfe);
        repeat (4) @(posedge clk_i);
        check_val("wait", 32'(lvl[0]), 32'(wait_n_o));
        wr(`WAIT_ENABLE_BITS_IDX, 8'hff);
        wr(`WAIT_CONTROL_REG_IDX, 8'h02);
        ext_level <= ~lvl;
        repeat (4) @(posedge clk_i);
        check_val("wait", {31'h0, ~lvl[0]}, 32'(wait_n_o));
        input_check();
        hw_standby_i <= 1'h1;
        repeat (8) @(posedge clk_i);
        check_val("pin oe", 32'h0, 32'(bus_pin_oe_o));
        hw_standby_i <= 1'h0;
        ext_drive <= 7'h00;
        repeat (3) @(posedge clk_i);
        wr(`BUS_PORT_DIRECTION_IDX, 8'h7f);
        repeat (2) @(posedge clk_i);
        rd(`BUS_PORT_OUTPUT_DATA_IDX, 8'h80);
        check_val("pin out", 32'h0, 32'(bus_pin_o));
        for (int k = 0; k < 50 && exp_q.size() != 0; k++) begin
            @(posedge clk_i);
        end
        if (exp_q.size() != 0) begin
            fails++;
        end
        stop_test();
    end
endmodule
